// ---- common/bbs_pkg.sv ----
// constants, types and map for the backlight boost sequencer
package bbs_pkg;
	// clock rate in MHz (5 ns period)
	localparam int CLK_MHZ = 200;
	// interval times in microseconds
	localparam int TSEL_US = 1000;
	localparam int TDEL_US = 2000;
	localparam int TW0_US  = 100;
	localparam int TW1_US  = 260;
	localparam int TOFF_US = 3000;
	// counter width, holds the longest interval
	localparam int CW = 20;
	// cycle counts derived from the times
	localparam logic [CW-1:0] SEL_CYC  = CW'(TSEL_US * CLK_MHZ);
	localparam logic [CW-1:0] DEL_CYC  = CW'(TDEL_US * CLK_MHZ);
	localparam logic [CW-1:0] TW0_CYC  = CW'(TW0_US * CLK_MHZ);
	localparam logic [CW-1:0] TW1_CYC  = CW'(TW1_US * CLK_MHZ);
	localparam logic [CW-1:0] TOFF_CYC = CW'(TOFF_US * CLK_MHZ);
	// consecutive overvoltage cycles before trip
	localparam logic [3:0] OVP_CYCLES = 4'h8;
	// register byte offsets
	localparam logic [3:0] ADDR_LEVEL  = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h4;
	localparam logic [3:0] ADDR_FBLVL  = 4'h8;
	// reset value of the level code, full scale
	localparam logic [4:0] LEVEL_RST = 5'h1F;
	// status field positions
	localparam int ST_STATE_LSB = 0;
	localparam int ST_DIG_BIT   = 3;
	localparam int ST_OVP_BIT   = 4;
	localparam int ST_UNDERVOLTAGE_LOCKOUT_BIT  = 5;
	localparam int ST_OT_BIT    = 6;
	localparam int ST_RUN_BIT   = 7;
	// full scale feedback in pulse-width mode, mV
	localparam logic [7:0] FB_FULL = 8'hC8;
	// level code to feedback target in mV
	localparam logic [7:0] FB_MV [32] = '{
		8'h00, 8'h05, 8'h08, 8'h0B, 8'h0E, 8'h11, 8'h14, 8'h17,
		8'h1A, 8'h1D, 8'h20, 8'h23, 8'h26, 8'h2C, 8'h32, 8'h38,
		8'h3E, 8'h44, 8'h4A, 8'h50, 8'h56, 8'h5C, 8'h62, 8'h68,
		8'h74, 8'h80, 8'h8C, 8'h98, 8'hA4, 8'hB0, 8'hBC, 8'hC8
	};
	// sequencer states
	typedef enum logic [2:0] {
		ST_OFF    = 3'h0,
		ST_SELECT = 3'h1,
		ST_DELAY  = 3'h2,
		ST_RUN    = 3'h3,
		ST_OVP    = 3'h4
	} bbs_state_type;
endpackage

// ---- common/bbs_cnt_if.sv ----
// interval counter control bundle
`timescale 1ns/100ps
interface bbs_cnt_if;
	logic                   clr;  // restart from zero
	logic                   en;   // count this cycle
	logic [bbs_pkg::CW-1:0] lim;  // target count
	logic                   done; // target reached
	modport ctl (output clr, output en, output lim, input done);
	modport cnt (input clr, input en, input lim, output done);
endinterface

// ---- src/bbs_counter.sv ----
// saturating interval counter
`timescale 1ns/100ps
module bbs_counter (
	input  wire logic clock_i,
	input  wire logic rstn_i,
	bbs_cnt_if.cnt    cnt
);
	logic [bbs_pkg::CW-1:0] count_q; // cycles counted
	logic [bbs_pkg::CW-1:0] count_d; // next count

	// done once the target is reached; stays until cleared
	assign cnt.done = (count_q >= cnt.lim);

	// saturate at target so done cannot wrap away
	assign count_d = cnt.clr ? '0 :
		(cnt.en && !cnt.done) ? count_q + 1'b1 : count_q;

	// count register
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			count_q <= '0;
		end else begin
			count_q <= count_d;
		end
	end
endmodule

// ---- src/bbs_top.sv ----
// startup, mode, shutdown and protection sequencer for the boost driver
`timescale 1ns/100ps
module bbs_top #(
	// interval lengths in cycles, shortened in simulation
	parameter logic [bbs_pkg::CW-1:0] SEL_CYC  = bbs_pkg::SEL_CYC,
	parameter logic [bbs_pkg::CW-1:0] DEL_CYC  = bbs_pkg::DEL_CYC,
	parameter logic [bbs_pkg::CW-1:0] TW0_CYC  = bbs_pkg::TW0_CYC,
	parameter logic [bbs_pkg::CW-1:0] TW1_CYC  = bbs_pkg::TW1_CYC,
	parameter logic [bbs_pkg::CW-1:0] TOFF_CYC = bbs_pkg::TOFF_CYC
) (
	input  wire logic        clock_i,
	input  wire logic        rstn_i,
	// dimming control line from the host
	input  wire logic        dim_control_line_i,
	// switch node above overvoltage threshold
	input  wire logic        switch_node_ovp_i,
	// one-cycle pulse at each switching cycle start
	input  wire logic        switch_cycle_i,
	// switch peak current above the limit
	input  wire logic        peak_over_limit_i,
	// supply input below lockout threshold
	input  wire logic        undervoltage_lockout_i,
	// die temperature too high
	input  wire logic        over_temp_i,
	// register port
	input  wire logic [3:0]  reg_addr_i,
	input  wire logic [31:0] reg_wdata_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	output logic      [31:0] reg_rdata_o,
	// sequencer outputs
	output logic             device_enable_o,
	output logic             boost_run_o,
	output logic             power_switch_on_o,
	output logic             pwm_dim_en_o,
	output logic             digital_mode_o,
	output logic             ovp_shutdown_o,
	output logic      [7:0]  feedback_level_o
);
	// sequencer state
	bbs_pkg::bbs_state_type state_q;
	bbs_pkg::bbs_state_type state_d;

	// previous line level for edge detection
	logic       line_q;
	// first fall seen during selection
	logic       fell_q;
	// line rose again after the first fall
	logic       blocked_q;
	// digital mode chosen
	logic       digital_q;
	// overvoltage seen in the current cycle
	logic       ovp_seen_q;
	// consecutive overvoltage cycle count
	logic [3:0] ovp_cnt_q;
	// registered outputs
	logic       boost_run_q;
	logic       sw_on_q;
	logic [7:0] fb_q;
	// software level code
	logic [4:0] level_q;
	// read data, valid one cycle after strobe
	logic [31:0] rdata_q;

	// decode and condition wires
	logic        line_rise;
	logic        in_select;
	logic        in_delay;
	logic        in_run;
	logic        ovp_now;
	logic        ovp_trip;
	logic        boost_ok;
	logic        dig_hit;
	logic        wr_level;
	logic [31:0] status_word;
	logic [31:0] rd_mux;
	logic [7:0]  fb_target;

	// counter bundles
	bbs_cnt_if win_if ();
	bbs_cnt_if hi_if ();
	bbs_cnt_if lo_if ();
	bbs_cnt_if off_if ();

	// window and delay timer, one counter reused
	bbs_counter u_win (
		.clock_i (clock_i),
		.rstn_i  (rstn_i),
		.cnt     (win_if)
	);
	// high time of first pulse
	bbs_counter u_hi (
		.clock_i (clock_i),
		.rstn_i  (rstn_i),
		.cnt     (hi_if)
	);
	// low time after first pulse
	bbs_counter u_lo (
		.clock_i (clock_i),
		.rstn_i  (rstn_i),
		.cnt     (lo_if)
	);
	// shutdown hold time
	bbs_counter u_off (
		.clock_i (clock_i),
		.rstn_i  (rstn_i),
		.cnt     (off_if)
	);

	// state decodes
	assign line_rise = dim_control_line_i & ~line_q;
	assign in_select = (state_q == bbs_pkg::ST_SELECT);
	assign in_delay  = (state_q == bbs_pkg::ST_DELAY);
	assign in_run    = (state_q == bbs_pkg::ST_RUN);

	// clocked interval timing
	// window timer restarts at every state change
	assign win_if.clr = (state_d != state_q);
	assign win_if.en  = in_select | in_delay;
	assign win_if.lim = in_select ? SEL_CYC : DEL_CYC;

	// first pulse high time
	// counts only while the first pulse is still high
	assign hi_if.clr = ~in_select;
	assign hi_if.en  = in_select & dim_control_line_i & ~fell_q;
	assign hi_if.lim = TW0_CYC;

	// following low time
	// low run restarts whenever the line goes high
	assign lo_if.clr = ~in_select | dim_control_line_i;
	assign lo_if.en  = in_select & ~dim_control_line_i;
	assign lo_if.lim = TW1_CYC;

	// low hold measure
	// any high level restarts the hold, so pulses never shut down
	assign off_if.clr = dim_control_line_i |
		(state_q == bbs_pkg::ST_OFF);
	assign off_if.en  = ~dim_control_line_i;
	assign off_if.lim = TOFF_CYC;

	// digital entry pattern
	// only the low right after the first long high counts
	assign dig_hit = in_select & hi_if.done & fell_q & ~blocked_q &
		lo_if.done;

	// consecutive cycles only
	// a late overvoltage in the closing cycle still counts
	assign ovp_now  = ovp_seen_q | switch_node_ovp_i;
	assign ovp_trip = (ovp_cnt_q == bbs_pkg::OVP_CYCLES);

	// over-temperature gate
	// heat stops the converter without changing state; lockout also forces the state to off
	assign boost_ok = in_run & ~over_temp_i & ~undervoltage_lockout_i;

	// code to feedback map
	// pulse-width mode sets full scale; the filtered duty scales it
	assign fb_target = digital_q ? bbs_pkg::FB_MV[level_q] :
		bbs_pkg::FB_FULL;

	// next-state logic
	always_comb begin
		state_d = state_q;
		if (undervoltage_lockout_i) begin
			state_d = bbs_pkg::ST_OFF;
		end else begin
			case (state_q)
				bbs_pkg::ST_OFF: begin
					if (line_rise) begin
						state_d = bbs_pkg::ST_SELECT;
					end
				end
				bbs_pkg::ST_SELECT: begin
					if (off_if.done) begin
						state_d = bbs_pkg::ST_OFF;
					end else if (win_if.done) begin
						state_d = bbs_pkg::ST_DELAY;
					end
				end
				bbs_pkg::ST_DELAY: begin
					if (off_if.done) begin
						state_d = bbs_pkg::ST_OFF;
					end else if (win_if.done) begin
						state_d = bbs_pkg::ST_RUN;
					end
				end
				bbs_pkg::ST_RUN: begin
					if (off_if.done) begin
						state_d = bbs_pkg::ST_OFF;
					end else if (ovp_trip) begin
						state_d = bbs_pkg::ST_OVP;
					end
				end
				// wait for fresh startup
				// line must go low for the hold, then rise again
				bbs_pkg::ST_OVP: begin
					if (off_if.done) begin
						state_d = bbs_pkg::ST_OFF;
					end
				end
				default: begin
					state_d = bbs_pkg::ST_OFF;
				end
			endcase
		end
	end

	// state and line history
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_q <= bbs_pkg::ST_OFF;
			line_q  <= 1'b0;
		end else begin
			state_q <= state_d;
			line_q  <= dim_control_line_i;
		end
	end

	// selection pattern tracking
	// flags live only inside the window and restart each startup
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			fell_q    <= 1'b0;
			blocked_q <= 1'b0;
		end else begin
			fell_q    <= in_select & (fell_q | ~dim_control_line_i);
			blocked_q <= in_select &
				(blocked_q | (fell_q & dim_control_line_i));
		end
	end

	// pulse-width by default
	// cleared at each startup, set only by the entry pattern
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			digital_q <= 1'b0;
		end else if (state_q == bbs_pkg::ST_OFF) begin
			digital_q <= 1'b0;
		end else if (dig_hit) begin
			digital_q <= 1'b1;
		end
	end

	// overvoltage cycle counting
	// sticky seen flag: the cycle-start clear wins; an event in that clock counts for the closing cycle
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ovp_seen_q <= 1'b0;
			ovp_cnt_q  <= 4'h0;
		end else if (!in_run) begin
			ovp_seen_q <= 1'b0;
			ovp_cnt_q  <= 4'h0;
		end else if (switch_cycle_i) begin
			ovp_seen_q <= 1'b0;
			ovp_cnt_q  <= ovp_now ? ovp_cnt_q + 4'h1 : 4'h0;
		end else begin
			ovp_seen_q <= ovp_now;
		end
	end

	// peak current blanking
	// limit wins over a new cycle start in the same clock
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sw_on_q <= 1'b0;
		end else if (!boost_ok || peak_over_limit_i) begin
			sw_on_q <= 1'b0;
		end else if (switch_cycle_i) begin
			sw_on_q <= 1'b1;
		end
	end

	// boost and dimming outputs
	// feedback held at zero until the converter runs
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			boost_run_q <= 1'b0;
			fb_q        <= 8'h00;
		end else begin
			boost_run_q <= boost_ok;
			fb_q        <= in_run ? fb_target : 8'h00;
		end
	end

	// register decodes
	assign wr_level    = reg_wr_i & (reg_addr_i == bbs_pkg::ADDR_LEVEL);
	assign status_word = {24'h00_0000,
		boost_run_q,
		over_temp_i,
		undervoltage_lockout_i,
		(state_q == bbs_pkg::ST_OVP),
		digital_q,
		state_q};
	// unmapped offsets read as zero
	assign rd_mux =
		(reg_addr_i == bbs_pkg::ADDR_LEVEL)  ? {27'h000_0000, level_q} :
		(reg_addr_i == bbs_pkg::ADDR_STATUS) ? status_word :
		(reg_addr_i == bbs_pkg::ADDR_FBLVL)  ? {24'h00_0000, fb_q} :
		32'h0000_0000;

	// level code register, stands in for the serial data byte
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			level_q <= bbs_pkg::LEVEL_RST;
		end else if (wr_level) begin
			level_q <= reg_wdata_i[4:0];
		end
	end

	// read data valid only in the cycle after the strobe
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rdata_q <= 32'h0000_0000;
		end else begin
			rdata_q <= reg_rd_i ? rd_mux : 32'h0000_0000;
		end
	end

	// output drive
	assign reg_rdata_o       = rdata_q;
	assign device_enable_o   = (state_q != bbs_pkg::ST_OFF);
	assign boost_run_o       = boost_run_q;
	assign power_switch_on_o = sw_on_q;
	assign pwm_dim_en_o      = boost_run_q & ~digital_q;
	assign digital_mode_o    = digital_q;
	assign ovp_shutdown_o    = (state_q == bbs_pkg::ST_OVP);
	assign feedback_level_o  = fb_q;
endmodule

// ---- sim/bbs_monitor.sv ----
// assertion checker for the boost sequencer, bound to its top
`timescale 1ns/100ps
module bbs_monitor #(
	parameter logic [bbs_pkg::CW-1:0] SEL_CYC  = bbs_pkg::SEL_CYC,
	parameter logic [bbs_pkg::CW-1:0] DEL_CYC  = bbs_pkg::DEL_CYC,
	parameter logic [bbs_pkg::CW-1:0] TOFF_CYC = bbs_pkg::TOFF_CYC
) (
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire logic dim_control_line_i,
	input wire logic switch_cycle_i,
	input wire logic peak_over_limit_i,
	input wire logic undervoltage_lockout_i,
	input wire logic over_temp_i,
	input wire logic device_enable_o,
	input wire logic boost_run_o,
	input wire logic power_switch_on_o,
	input wire logic pwm_dim_en_o,
	input wire logic digital_mode_o,
	input wire logic ovp_shutdown_o
);
	logic [bbs_pkg::CW-1:0] on_cnt_q;  // cycles with device enabled
	logic [bbs_pkg::CW-1:0] low_cnt_q; // consecutive low line cycles
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rstn_i);
	// both counters saturate so a long run never wraps
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			on_cnt_q  <= '0;
			low_cnt_q <= '0;
		end else begin
			if (!device_enable_o)
				on_cnt_q <= '0;
			else if (on_cnt_q != '1)
				on_cnt_q <= on_cnt_q + 1'b1;
			if (dim_control_line_i)
				low_cnt_q <= '0;
			else if (low_cnt_q != '1)
				low_cnt_q <= low_cnt_q + 1'b1;
		end
	end
	AST_ENABLE_ON_RISE: assert property (
		!device_enable_o && !undervoltage_lockout_i &&
		$rose(dim_control_line_i) |-> ##[1:2] device_enable_o)
		else $error("enable missing after line rise");
	AST_RUN_AFTER_DELAY: assert property (
		$rose(boost_run_o) |-> on_cnt_q >= SEL_CYC + DEL_CYC)
		else $error("boost started before window and delay");
	AST_PWM_AFTER_DELAY: assert property (
		$rose(pwm_dim_en_o) |-> on_cnt_q >= SEL_CYC + DEL_CYC)
		else $error("pulse-width dimming enabled too early");
	AST_PWM_EXCLUSIVE: assert property (
		pwm_dim_en_o |-> boost_run_o && !digital_mode_o)
		else $error("pulse-width dimming outside its mode");
	AST_SHUTDOWN_HOLD: assert property (
		low_cnt_q > TOFF_CYC + 3 |-> !device_enable_o)
		else $error("still enabled after long low hold");
	AST_OVP_STOPS: assert property (
		ovp_shutdown_o [*2] |-> !boost_run_o)
		else $error("boost running in overvoltage shutdown");
	AST_OVP_EXIT: assert property (
		$fell(ovp_shutdown_o) |-> !device_enable_o)
		else $error("overvoltage left other than to off");
	AST_OCP_CUT: assert property (
		peak_over_limit_i && !switch_cycle_i |=> !power_switch_on_o)
		else $error("switch not cut on overcurrent");
	AST_OCP_STAYS_OFF: assert property (
		!power_switch_on_o && !switch_cycle_i |=> !power_switch_on_o)
		else $error("switch back on within the cycle");
	AST_UNDERVOLTAGE_LOCKOUT_LOCK: assert property (
		undervoltage_lockout_i |=> !boost_run_o)
		else $error("boost running in lockout");
	AST_OT_STOP: assert property (
		over_temp_i [*2] |-> !boost_run_o)
		else $error("boost running when overheated");
endmodule
bind bbs_top bbs_monitor #(
	.SEL_CYC(SEL_CYC), .DEL_CYC(DEL_CYC), .TOFF_CYC(TOFF_CYC)
) i_mon (
	.clock_i(clock_i), .rstn_i(rstn_i),
	.dim_control_line_i(dim_control_line_i),
	.switch_cycle_i(switch_cycle_i),
	.peak_over_limit_i(peak_over_limit_i),
	.undervoltage_lockout_i(undervoltage_lockout_i),
	.over_temp_i(over_temp_i), .device_enable_o(device_enable_o),
	.boost_run_o(boost_run_o), .power_switch_on_o(power_switch_on_o),
	.pwm_dim_en_o(pwm_dim_en_o), .digital_mode_o(digital_mode_o),
	.ovp_shutdown_o(ovp_shutdown_o)
);

// ---- sim/bbs_host.sv ----
// host controller model driving the dimming control line
`timescale 1ns/100ps
module bbs_host (
	input  wire logic clock_i,
	output logic      line_o
);
	// line idles low until the first startup
	initial line_o = 1'b0;
	// hold one level for n cycles, changed just after an edge
	task automatic drive(input logic lvl, input int n);
		@(posedge clock_i);
		line_o <= lvl;
		repeat (n) @(posedge clock_i);
	endtask
	// long high, then low, then idle high
	task automatic digital_entry(input int hi, input int lo);
		drive(1'b1, hi);
		drive(1'b0, lo);
		drive(1'b1, 1);
	endtask
	// low hold turns the device off
	// a later rise is the fresh startup
	task automatic shutdown(input int n);
		drive(1'b0, n);
	endtask
endmodule

// ---- sim/bbs_top_bench.sv ----
// self-checking bench for the boost sequencer
`timescale 1ns/100ps
module bbs_top_bench;
	// short intervals keep the run brief
	localparam logic [19:0] SEL  = 20'h0_0064;
	localparam logic [19:0] DEL  = 20'h0_00C8;
	localparam logic [19:0] TW0  = 20'h0_000A;
	localparam logic [19:0] TW1  = 20'h0_001A;
	localparam logic [19:0] TOFF = 20'h0_012C;
	logic        clock_i, rstn_i, line, ovp, swc, peak, undervoltage_lockout, ot, wr, rd;
	logic [3:0]  addr;
	logic [31:0] wdata, rdata, d;
	logic        en, run, sw_on, pwm, dig, ovp_off;
	logic [7:0]  fb;
	int          n_errors, n_checks, n;
	bbs_host i_host (.clock_i(clock_i), .line_o(line));
	bbs_top #(.SEL_CYC(SEL), .DEL_CYC(DEL), .TW0_CYC(TW0), .TW1_CYC(TW1),
		.TOFF_CYC(TOFF)) i_dut (
		.clock_i(clock_i), .rstn_i(rstn_i), .dim_control_line_i(line),
		.switch_node_ovp_i(ovp), .switch_cycle_i(swc),
		.peak_over_limit_i(peak), .undervoltage_lockout_i(undervoltage_lockout),
		.over_temp_i(ot), .reg_addr_i(addr), .reg_wdata_i(wdata),
		.reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
		.device_enable_o(en), .boost_run_o(run), .power_switch_on_o(sw_on),
		.pwm_dim_en_o(pwm), .digital_mode_o(dig), .ovp_shutdown_o(ovp_off),
		.feedback_level_o(fb));
	// free-running 200 MHz clock
	initial begin
		clock_i = 1'b0;
		forever #2.5 clock_i = ~clock_i;
	end
	task automatic close_out();
		if (n_errors == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic check(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	// let k edges pass, then look once outputs settled
	task automatic idle(input int k);
		repeat (k) @(posedge clock_i);
		#1;
	endtask
	task automatic wr32(input logic [3:0] a, input logic [31:0] v);
		@(posedge clock_i);
		wr <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clock_i);
		wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd32(input logic [3:0] a, output logic [31:0] v);
		@(posedge clock_i);
		rd <= 1'b1;
		addr <= a;
		@(posedge clock_i);
		rd <= 1'b0;
		#1 v = rdata;
	endtask
	// bounded wait for the converter to run
	task automatic wait_run(output int k);
		k = 0;
		while (run !== 1'b1 && k < 2000) begin
			@(posedge clock_i);
			#1 k++;
		end
		if (k >= 2000) begin
			n_errors++;
			$display("CHECK FAILED run wait expected 1 seen 0");
			close_out();
		end
	endtask
	// k switching cycles, each a one-cycle pulse and a gap
	task automatic pulse(input int k);
		repeat (k) begin
			@(posedge clock_i);
			swc <= 1'b1;
			@(posedge clock_i);
			swc <= 1'b0;
			repeat (3) @(posedge clock_i);
		end
	endtask
	initial begin
		rstn_i = 1'b0;
		{ovp, swc, peak, undervoltage_lockout, ot, wr, rd} = '0;
		addr = '0;
		wdata = '0;
		n_errors = 0;
		n_checks = 0;
		repeat (6) @(posedge clock_i);
		rstn_i <= 1'b1;
		idle(1);
		// reset values and an unmapped read
		rd32(4'h0, d);
		check("level", 32'h0000_001F, d);
		rd32(4'h4, d);
		check("status", 32'h0000_0000, d);
		rd32(4'hC, d);
		check("unmapped", 32'h0000_0000, d);
		// line stays high through the window: pulse-width mode
		i_host.drive(1'b1, 1);
		idle(1);
		check("enable", 32'h0000_0001, {31'h0, en});
		wait_run(n);
		d = 32'(n >= SEL + DEL && n <= SEL + DEL + 8);
		check("delay", 32'h0000_0001, d);
		check("digital", 32'h0000_0000, {31'h0, dig});
		check("pwm en", 32'h0000_0001, {31'h0, pwm});
		check("fb pwm", 32'h0000_00C8, {24'h0, fb});
		// over-temperature stops and releases the boost
		@(posedge clock_i);
		ot <= 1'b1;
		idle(3);
		check("run hot", 32'h0000_0000, {31'h0, run});
		@(posedge clock_i);
		ot <= 1'b0;
		idle(3);
		check("run cool", 32'h0000_0001, {31'h0, run});
		// overcurrent blanks the switch till the next cycle
		pulse(1);
		idle(1);
		check("switch on", 32'h0000_0001, {31'h0, sw_on});
		@(posedge clock_i);
		peak <= 1'b1;
		@(posedge clock_i);
		peak <= 1'b0;
		idle(3);
		check("switch cut", 32'h0000_0000, {31'h0, sw_on});
		// a clean cycle restarts the overvoltage count
		@(posedge clock_i);
		ovp <= 1'b1;
		pulse(6);
		@(posedge clock_i);
		ovp <= 1'b0;
		pulse(2);
		@(posedge clock_i);
		ovp <= 1'b1;
		pulse(7);
		idle(2);
		check("ovp at 7", 32'h0000_0000, {31'h0, ovp_off});
		pulse(1);
		idle(2);
		check("ovp at 8", 32'h0000_0001, {31'h0, ovp_off});
		// status: overvoltage flag set, state code four, boost stopped
		rd32(4'h4, d);
		check("status ovp", 32'h0000_0014, d);
		@(posedge clock_i);
		ovp <= 1'b0;
		// a rise without low hold does not restart
		i_host.drive(1'b0, 5);
		i_host.drive(1'b1, 5);
		idle(1);
		check("ovp kept", 32'h0000_0001, {31'h0, ovp_off});
		i_host.shutdown(TOFF + 8);
		idle(1);
		check("off", 32'h0000_0000, {31'h0, en});
		// digital entry, then the top level codes
		i_host.digital_entry(TW0 + 4, TW1 + 4);
		wait_run(n);
		check("digital", 32'h0000_0001, {31'h0, dig});
		check("pwm off", 32'h0000_0000, {31'h0, pwm});
		for (int c = 29; c < 32; c++) begin
			wr32(4'h0, 32'(c));
			idle(3);
			check("fb code", 32'(176 + 12 * (c - 29)), {24'h0, fb});
		end
		// full scale code read back through the feedback register
		rd32(4'h8, d);
		check("fb reg", 32'h0000_00C8, d);
		// supply lockout forces everything off
		@(posedge clock_i);
		undervoltage_lockout <= 1'b1;
		idle(3);
		check("undervoltage_lockout enable", 32'h0000_0000, {31'h0, en});
		check("undervoltage_lockout run", 32'h0000_0000, {31'h0, run});
		close_out();
	end
endmodule
